/* File: verilog/port_power_map.svh */
// Purpose: positions and timing counts for the port power block
// Assumes: core clock of 10 MHz
// Notes:   mask and cycle counts feed top-level parameters so a bench can shorten them
`ifndef PORT_POWER_MAP_SVH
`define PORT_POWER_MAP_SVH

`define CLOCK_PERIOD_NS   100
// fault must persist this long before it counts
`define MASK_TIME_US      1000
`define MASK_CYCLES       ((`MASK_TIME_US * 1000) / `CLOCK_PERIOD_NS)
// auto-recovery re-check period
`define CYCLE_TIME_MS     100
`define CYCLE_CYCLES      ((`CYCLE_TIME_MS * 1000000) / `CLOCK_PERIOD_NS)
// discharge pulse on the way into active, a least time: rounded up
`define DISCHARGE_TIME_US 200
`define DISCHARGE_CYCLES  \
  (((`DISCHARGE_TIME_US * 1000) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`define COUNT_WIDTH       20
// bit positions of the maskable fault vector
`define FLT_OVER_CURRENT  0
`define FLT_BUS_UV        1
`define FLT_BV_SOURCE     2
`define FLT_BV_CORE       3
`define FLT_DISCHARGE     4
`define FLT_SOURCE_OV     5
`define FLT_COUNT         6
// strap layout
`define STRAP_COMM_BIT    3
`define SYNC_WIDTH        21

`endif

/* File: verilog/port_power_pkg.sv */
// Purpose: shared types of the port power block
// Assumes: constants live in port_power_map.svh
// Notes:   struct order is fixed, the sync vector relies on the widths
package port_power_pkg;

  typedef enum logic [2:0] {st_sleep, st_detect, st_entry, st_active, st_error} state_t;

  // analog comparator and detector results, all asynchronous
  typedef struct packed {
    logic source_uv;
    logic source_ov;
    logic die_hot;
    logic over_current;
    logic bus_uv;
    logic bv_source;
    logic bv_core;
    logic discharge_err;
    logic attach_seen;
    logic removal_seen;
  } analog_t;

  // discrete control pins, asynchronous
  typedef struct packed {
    logic port_power_permit;
    logic attach_watch_enable;
    logic mode_bit_a;
    logic mode_bit_b;
    logic emulation_on;
    logic fault_hold_pin;
    logic polarity_strap;
  } pin_t;

  // host-written configuration bits, core clock domain
  typedef struct packed {
    logic mode_bit_a_cfg;
    logic mode_bit_b_cfg;
    logic emulation_on_cfg;
    logic port_power_permit_cfg;
    logic attach_watch_cfg;
    logic fault_hold_bit;
    logic ignore_pins_bit;
    logic enable_behaviour_otp;
  } cfg_t;

  typedef struct packed {
    logic power;
    logic bypass;
    logic high_speed;
    logic discharge;
  } switch_t;

endpackage

/* File: verilog/port_power_ctrl.sv */
// Purpose: power state, switch and fault control of a usb port power switch
// Assumes: one 10 MHz core clock, comparators asynchronous to it
// Notes:   host config bits come from logic on the core clock
//
// Overview of operation
// - no active or switch while blocked
// - active goes to error on any fault
// - detect errors only on backdrive, overtemperature
// - sleep errors only on backdrive
// - error opens all switches, asserts alert
// - latched: clear flag or toggle permit
// - auto-recovery re-checks every cycle period
// - clean re-check returns, restarting active mode
// - removal in error re-checks, picks state
// - source backvoltage opens switch, masked error
// - core backvoltage opens bypass, masked error
// - lasting source overvoltage enters error from entry or active
// - strap sets limit and comm mode
// - polarity strap latched once at power-up
// - modes zero with permit: detection off
// - ignore bit drops mode pins in smbus
// - ignore bit drops permit pin in smbus
// - switch never closed without permit
// - fault hold from pin or bit
// - attach watch with otp behaviour bit requires attach before power
// - attach watch from bit or pin
// - detect to active ordered sequence
// - faults other than overtemperature persist mask time before alert
`timescale 1ns/100ps
`include "port_power_map.svh"

module port_power_ctrl #(
  parameter int mask_cycles  = `MASK_CYCLES,
  parameter int cycle_cycles = `CYCLE_CYCLES
) (
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire port_power_pkg::analog_t analog_async,
  input  wire port_power_pkg::pin_t    pins_async,
  input  wire logic [3:0]              interface_and_limit_strap,
  input  wire port_power_pkg::cfg_t    cfg,
  input  wire logic                    fault_clear,
  output port_power_pkg::switch_t      switches,
  output logic                         alert_n,
  output port_power_pkg::state_t       power_state,
  output logic                         fault_flag,
  output logic                         back_voltage_flag,
  output logic                         attach_detect_on,
  output logic                         removal_detect_on,
  output logic                         smbus_mode,
  output logic [2:0]                   limit_code,
  output logic                         polarity_high
);

  localparam int dis_cycles = `DISCHARGE_CYCLES;

  // two-flop synchroniser on every async bit
  logic [`SYNC_WIDTH-1:0] meta_reg;
  logic [`SYNC_WIDTH-1:0] sync_reg;
  wire  [`SYNC_WIDTH-1:0] async_vec = {analog_async, pins_async, interface_and_limit_strap};

  for (genvar i = 0; i < `SYNC_WIDTH; i++) begin : g_sync
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        meta_reg[i] <= 1'b0;
        sync_reg[i] <= 1'b0;
      end else begin
        meta_reg[i] <= async_vec[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  port_power_pkg::analog_t a;
  port_power_pkg::pin_t    p;
  logic [3:0]              strap_s;
  assign {a, p, strap_s} = sync_reg;

  // strap capture on the first edge after the sync chain has filled
  logic [1:0] strap_wait_reg;
  logic       strap_taken_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_wait_reg  <= 2'h0;
      strap_taken_reg <= 1'b0;
      smbus_mode      <= 1'b0;
      limit_code      <= 3'h0;
      polarity_high   <= 1'b1;
    end else if (!strap_taken_reg) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
      if (strap_wait_reg == 2'h2) begin
        strap_taken_reg <= 1'b1;
        smbus_mode      <= strap_s[`STRAP_COMM_BIT];
        limit_code      <= strap_s[2:0];
        polarity_high   <= p.polarity_strap;
      end
    end
  end

  // control selection between pins and host bits
  wire pins_used  = !(smbus_mode && cfg.ignore_pins_bit);
  wire pin_permit = polarity_high ? p.port_power_permit : !p.port_power_permit;
  wire permit     = smbus_mode ? (cfg.port_power_permit_cfg || (pins_used && pin_permit))
                               : pin_permit;
  wire [2:0] mode_pin = {p.mode_bit_a, p.mode_bit_b, p.emulation_on};
  wire [2:0] mode_cfg = {cfg.mode_bit_a_cfg, cfg.mode_bit_b_cfg, cfg.emulation_on_cfg};
  wire [2:0] modes    = smbus_mode ? (mode_cfg | (pins_used ? mode_pin : 3'h0))
                                   : mode_pin;
  wire modes_zero  = (modes == 3'h0);
  wire watch       = smbus_mode ? cfg.attach_watch_cfg : p.attach_watch_enable;
  wire latch_mode  = smbus_mode ? cfg.fault_hold_bit : p.fault_hold_pin;
  wire detect_kill = modes_zero && permit;

  // edge detection on synced detector and permit levels
  logic attach_d_reg;
  logic removal_d_reg;
  logic permit_d_reg;
  wire  attach_edge  = a.attach_seen && !attach_d_reg && attach_detect_on;
  wire  removal_edge = a.removal_seen && !removal_d_reg && removal_detect_on;
  wire  permit_flip  = permit != permit_d_reg;

  port_power_pkg::state_t state_reg;
  port_power_pkg::state_t state_next;
  port_power_pkg::state_t target;

  // attach memory, forgotten on removal, sleep or watch off
  logic attached_reg;
  wire  attached_next = (attached_reg || attach_edge) && !removal_edge && watch
                        && (state_reg != port_power_pkg::st_sleep);
  // a removal in this very cycle already counts as detached, so error exits to detect
  wire  need_attach   = watch && cfg.enable_behaviour_otp
                        && (!attached_reg || removal_edge);

  // state the controls ask for
  always_comb begin
    if (!strap_taken_reg || (!permit && !watch) || detect_kill)
      target = port_power_pkg::st_sleep;
    else if (!permit || a.source_uv || need_attach)
      target = watch ? port_power_pkg::st_detect : port_power_pkg::st_sleep;
    else
      target = port_power_pkg::st_entry;
  end

  // back-voltage hits: raised while the switch was closed, held while the back voltage lasts
  logic bv_src_hit_reg;
  logic bv_core_hit_reg;
  wire  bv_src_hit_next  = a.bv_source && (bv_src_hit_reg || switches.power);
  wire  bv_core_hit_next = a.bv_core && (bv_core_hit_reg || switches.bypass);
  wire  in_sleep         = (state_reg == port_power_pkg::st_sleep);

  // maskable fault levels
  wire [`FLT_COUNT-1:0] raw;
  assign raw[`FLT_OVER_CURRENT] = a.over_current;
  assign raw[`FLT_BUS_UV]       = a.bus_uv;
  assign raw[`FLT_BV_SOURCE]    = bv_src_hit_reg || (in_sleep && a.bv_source);
  assign raw[`FLT_BV_CORE]      = bv_core_hit_reg || (in_sleep && a.bv_core);
  assign raw[`FLT_DISCHARGE]    = a.discharge_err;
  assign raw[`FLT_SOURCE_OV]    = a.source_ov;

  // per-fault mask counters, saturating at the mask count
  logic [`COUNT_WIDTH-1:0] mask_cnt_reg [`FLT_COUNT];
  logic [`FLT_COUNT-1:0]   qual;
  for (genvar f = 0; f < `FLT_COUNT; f++) begin : g_mask
    assign qual[f] = (mask_cnt_reg[f] == `COUNT_WIDTH'(mask_cycles));
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
        mask_cnt_reg[f] <= '0;
      else if (!raw[f])
        mask_cnt_reg[f] <= '0;
      else if (!qual[f])
        mask_cnt_reg[f] <= mask_cnt_reg[f] + `COUNT_WIDTH'(1);
    end
  end

  // per-state fault sets; thermal skips the mask
  wire bv_q       = qual[`FLT_BV_SOURCE] || qual[`FLT_BV_CORE];
  wire err_active = a.die_hot || (qual != '0);
  wire err_detect = a.die_hot || bv_q;
  wire err_sleep  = bv_q;
  wire all_clear  = !a.die_hot && (raw == '0) && !a.bv_source && !a.bv_core;

  // recovery timer, runs only in error
  logic [`COUNT_WIDTH-1:0] cyc_cnt_reg;
  wire  cyc_done   = (cyc_cnt_reg == `COUNT_WIDTH'(cycle_cycles));
  wire  in_error   = (state_reg == port_power_pkg::st_error);
  wire  recheck    = (latch_mode && (fault_clear || permit_flip))
                     || (!latch_mode && cyc_done)
                     || removal_edge;
  // discharge step counter for the way into active
  logic [`COUNT_WIDTH-1:0] dis_cnt_reg;
  wire  dis_done   = (dis_cnt_reg == `COUNT_WIDTH'(dis_cycles));

  // power state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      port_power_pkg::st_sleep: begin
        if (err_sleep)
          state_next = port_power_pkg::st_error;
        else
          state_next = target;
      end
      port_power_pkg::st_detect: begin
        if (err_detect)
          state_next = port_power_pkg::st_error;
        else
          state_next = target;
      end
      port_power_pkg::st_entry: begin
        if (err_active)
          state_next = port_power_pkg::st_error;
        else if (target != port_power_pkg::st_entry)
          state_next = target;
        else if (dis_done)
          state_next = port_power_pkg::st_active;
      end
      port_power_pkg::st_active: begin
        if (err_active)
          state_next = port_power_pkg::st_error;
        else if (target != port_power_pkg::st_entry)
          state_next = target;
      end
      port_power_pkg::st_error: begin
        if (recheck && all_clear)
          state_next = target;
      end
      default: state_next = port_power_pkg::st_sleep;
    endcase
  end

  wire [`COUNT_WIDTH-1:0] dis_cnt_next =
    (state_next == port_power_pkg::st_entry && state_reg == port_power_pkg::st_entry)
    ? dis_cnt_reg + `COUNT_WIDTH'(1) : '0;

  // switch drive; every path into active restarts through entry
  wire to_active = (state_next == port_power_pkg::st_active);
  port_power_pkg::switch_t sw_next;
  assign sw_next.power      = to_active && permit && !bv_src_hit_next;
  assign sw_next.bypass     = (state_next == port_power_pkg::st_detect)
                              && !bv_core_hit_next;
  assign sw_next.high_speed = to_active;
  assign sw_next.discharge  = (state_next == port_power_pkg::st_entry)
                              && (dis_cnt_next != '0);

  // detection enables follow state and watch
  wire attach_det_next  = watch && !detect_kill
                          && (state_next == port_power_pkg::st_detect);
  wire removal_det_next = watch && !detect_kill
                          && (state_next != port_power_pkg::st_sleep);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg         <= port_power_pkg::st_sleep;
      switches          <= '0;
      alert_n           <= 1'b1;
      fault_flag        <= 1'b0;
      attach_detect_on  <= 1'b0;
      removal_detect_on <= 1'b0;
      attached_reg      <= 1'b0;
      bv_src_hit_reg    <= 1'b0;
      bv_core_hit_reg   <= 1'b0;
      dis_cnt_reg       <= '0;
      attach_d_reg      <= 1'b0;
      removal_d_reg     <= 1'b0;
      permit_d_reg      <= 1'b0;
    end else begin
      state_reg         <= state_next;
      switches          <= sw_next;
      alert_n           <= (state_next != port_power_pkg::st_error);
      fault_flag        <= (state_next == port_power_pkg::st_error);
      attach_detect_on  <= attach_det_next;
      removal_detect_on <= removal_det_next;
      attached_reg      <= attached_next;
      bv_src_hit_reg    <= bv_src_hit_next;
      bv_core_hit_reg   <= bv_core_hit_next;
      dis_cnt_reg       <= dis_cnt_next;
      attach_d_reg      <= a.attach_seen;
      removal_d_reg     <= a.removal_seen;
      permit_d_reg      <= permit;
    end
  end
  assign power_state = state_reg;

  // recovery timer restarts each period so auto mode keeps polling
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      cyc_cnt_reg <= '0;
    else if (!in_error || cyc_done)
      cyc_cnt_reg <= '0;
    else
      cyc_cnt_reg <= cyc_cnt_reg + `COUNT_WIDTH'(1);
  end

  // sticky back-voltage flag; a new event beats the clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      back_voltage_flag <= 1'b0;
    else if (qual[`FLT_BV_SOURCE] || qual[`FLT_BV_CORE])
      back_voltage_flag <= 1'b1;
    else if (fault_clear)
      back_voltage_flag <= 1'b0;
  end

  // checks
  a_switch_permit: assert property (@(posedge clock) disable iff (!arst_n)
    switches.power |-> $past(permit))
    else $error("power switch closed without permit");
  a_error_open: assert property (@(posedge clock) disable iff (!arst_n)
    power_state == port_power_pkg::st_error |-> switches == '0 && !alert_n)
    else $error("switch closed or alert idle in error");
  a_blocked_active: assert property (@(posedge clock) disable iff (!arst_n)
    (a.source_uv || !permit) && state_reg != port_power_pkg::st_error
    |=> power_state != port_power_pkg::st_active)
    else $error("active while blocked");
  a_bv_open_now: assert property (@(posedge clock) disable iff (!arst_n)
    a.bv_source && switches.power |=> !switches.power)
    else $error("switch not opened on back voltage");
  a_mask_wait: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(raw[`FLT_OVER_CURRENT]) ##1 raw[`FLT_OVER_CURRENT] && !a.die_hot
    |-> !qual[`FLT_OVER_CURRENT])
    else $error("fault qualified before mask time");
  a_sleep_error: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == port_power_pkg::st_sleep && !bv_q
    |=> state_reg != port_power_pkg::st_error)
    else $error("sleep left for error without backdrive");
  a_latch_hold: assert property (@(posedge clock) disable iff (!arst_n)
    in_error && latch_mode && !fault_clear && !permit_flip && !removal_edge
    |=> in_error)
    else $error("latched error left without clear");
  a_entry_order: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(switches.discharge) |-> !switches.bypass && !switches.power
    && !attach_detect_on)
    else $error("discharge overlaps another switch");
  a_detect_kill: assert property (@(posedge clock) disable iff (!arst_n)
    detect_kill |=> !attach_detect_on && !removal_detect_on)
    else $error("detection on with modes zero");
  a_strap_fixed: assert property (@(posedge clock) disable iff (!arst_n)
    strap_taken_reg |=> $stable(polarity_high) && $stable(smbus_mode))
    else $error("strap value changed after capture");

endmodule

/* File: bench/host_model.sv */
// Purpose: host side model that writes config bits and clears faults
// Assumes: bench calls the tasks from its main sequence
// Notes:   drives only at the falling edge, as the rest of the bench does
`timescale 1ns/100ps

module host_model (
  input  wire logic            clock,
  output port_power_pkg::cfg_t cfg,
  output logic                 fault_clear
);
  // config starts cleared so the permit and mode pins decide until written
  initial begin
    cfg         = '0;
    fault_clear = 1'b0;
  end

  // config bits are levels, changed away from the sampling edge
  task automatic write_cfg(input port_power_pkg::cfg_t v);
    @(negedge clock);
    cfg = v;
  endtask

  // one-cycle clear pulse, the host's way out of a latched error
  task automatic clear_fault();
    @(negedge clock);
    fault_clear = 1'b1;
    @(negedge clock);
    fault_clear = 1'b0;
  endtask
endmodule

/* File: bench/port_power_ctrl_tb.sv */
// Purpose: self-checking bench for the port power control block
// Assumes: short mask and cycle counts, discharge length from the header
// Notes:   stand-alone run first, then a second power-up in smbus mode
`timescale 1ns/100ps
`include "port_power_map.svh"

module port_power_ctrl_tb;
  localparam int mask_n  = 8;
  localparam int cycle_n = 20;
  localparam int flt_bit[6] = '{8, 7, 6, 5, 4, 2};
  localparam int long_n  = `DISCHARGE_CYCLES + 200;

  logic                    clock;
  logic                    arst_n;
  port_power_pkg::analog_t an;
  port_power_pkg::pin_t    pin;
  logic [3:0]              strap;
  port_power_pkg::cfg_t    cfg;
  port_power_pkg::cfg_t    cv;
  logic                    fault_clear;
  port_power_pkg::switch_t sw;
  logic                    alert_n;
  port_power_pkg::state_t  ps;
  logic                    fault_flag;
  logic                    bv_flag;
  logic                    att_on;
  logic                    rem_on;
  logic                    smbus;
  logic [2:0]              limit;
  logic                    pol_high;
  int                      n_mismatch;
  int                      n_checks;

  port_power_ctrl #(.mask_cycles(mask_n), .cycle_cycles(cycle_n)) u_port_power_ctrl (
    .clock(clock), .arst_n(arst_n), .analog_async(an), .pins_async(pin),
    .interface_and_limit_strap(strap), .cfg(cfg), .fault_clear(fault_clear),
    .switches(sw), .alert_n(alert_n), .power_state(ps), .fault_flag(fault_flag),
    .back_voltage_flag(bv_flag), .attach_detect_on(att_on), .removal_detect_on(rem_on),
    .smbus_mode(smbus), .limit_code(limit), .polarity_high(pol_high)
  );

  host_model u_host_model (.clock(clock), .cfg(cfg), .fault_clear(fault_clear));

  // free-running 10 MHz core clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask

  // bounded wait; a state never reached ends the run at once
  task automatic wait_state(input port_power_pkg::state_t s, input int bound);
    int i;
    i = 0;
    while (ps !== s && i < bound) begin
      @(negedge clock);
      i++;
    end
    check(8'(ps), 8'(s), "state");
    if (ps !== s) end_of_test();
  endtask

  // straps must be steady across release, they are captured once
  task automatic power_up(input logic [3:0] s);
    arst_n = 1'b0;
    strap  = s;
    cycles(20);
    arst_n = 1'b1;
    cycles(8);
  endtask

  initial begin
    arst_n     = 1'b0;
    an         = '0;
    pin        = '0;
    strap      = 4'h5;
    n_mismatch = 0;
    n_checks   = 0;
    // stand-alone: permit on, all modes zero
    pin.port_power_permit = 1'b1;
    pin.polarity_strap    = 1'b1;
    power_up(4'h5);
    check(8'(limit), 8'h05, "limit");
    check(8'(smbus), 8'h00, "smbus");
    check(8'(ps), 8'(port_power_pkg::st_sleep), "modes zero");
    check({6'h00, att_on, rem_on}, 8'h00, "detection");
    pin.polarity_strap = 1'b0;
    strap = 4'hb;
    cycles(6);
    check({4'h0, pol_high, limit}, 8'h0d, "straps held");
    pin.mode_bit_a = 1'b1;
    wait_state(port_power_pkg::st_active, long_n);
    check(8'(sw.power), 8'h01, "power on");
    // short faults stay below the mask and raise no error
    an.over_current = 1'b1;
    cycles(4);
    an.over_current = 1'b0;
    cycles(15);
    check({alert_n, 4'h0, ps}, 8'h83, "masked blip");
    an.bv_source = 1'b1;
    cycles(4);
    check(8'(sw.power), 8'h00, "bv opens");
    an.bv_source = 1'b0;
    cycles(6);
    check({sw.power, 4'h0, ps}, 8'h83, "bv recloses");
    // every fault kind but core backvoltage from active, auto-recovery each time
    foreach (flt_bit[k]) begin
      an[flt_bit[k]] = 1'b1;
      wait_state(port_power_pkg::st_error, 40);
      check({sw, alert_n, fault_flag, 2'h0}, 8'h04, "error outputs");
      an[flt_bit[k]] = 1'b0;
      wait_state(port_power_pkg::st_active, long_n);
    end
    check(8'(bv_flag), 8'h01, "bv flag");
    // latched handling holds error past the recovery period
    pin.fault_hold_pin = 1'b1;
    an.over_current = 1'b1;
    wait_state(port_power_pkg::st_error, 40);
    an.over_current = 1'b0;
    cycles(4 * cycle_n);
    check(8'(ps), 8'(port_power_pkg::st_error), "latched");
    u_host_model.clear_fault();
    wait_state(port_power_pkg::st_active, long_n);
    pin.port_power_permit = 1'b0;
    wait_state(port_power_pkg::st_sleep, 10);
    check(8'(sw), 8'h00, "no permit");
    // smbus power-up: pins ignored, config decides
    cv = '0;
    cv.ignore_pins_bit = 1'b1;
    u_host_model.write_cfg(cv);
    pin.port_power_permit   = 1'b0; // active once the low polarity is latched
    pin.attach_watch_enable = 1'b1;
    pin.fault_hold_pin      = 1'b0;
    power_up(4'hb);
    check({3'h0, pol_high, smbus, limit}, 8'h0b, "smbus strap");
    check(8'(ps), 8'(port_power_pkg::st_sleep), "pins ignored");
    cv.port_power_permit_cfg = 1'b1;
    cv.mode_bit_a_cfg        = 1'b1;
    cv.attach_watch_cfg      = 1'b1;
    cv.enable_behaviour_otp  = 1'b1;
    cv.fault_hold_bit        = 1'b1;
    u_host_model.write_cfg(cv);
    wait_state(port_power_pkg::st_detect, 10);
    check({sw.power, att_on}, 8'h01, "waiting attach");
    an.over_current = 1'b1;
    cycles(20);
    check(8'(ps), 8'(port_power_pkg::st_detect), "detect ignores oc");
    an.over_current = 1'b0;
    an.attach_seen  = 1'b1;
    wait_state(port_power_pkg::st_entry, 10);
    check({att_on, sw.bypass, sw.power}, 8'h00, "entry order");
    cycles(3);
    check(8'(sw.discharge), 8'h01, "discharge");
    wait_state(port_power_pkg::st_active, long_n);
    check({sw.power, sw.discharge}, 8'h02, "active power");
    // removal while latched in error re-checks and picks the state
    an.bus_uv = 1'b1;
    wait_state(port_power_pkg::st_error, 40);
    an.bus_uv      = 1'b0;
    an.attach_seen = 1'b0;
    cycles(4 * cycle_n);
    check(8'(ps), 8'(port_power_pkg::st_error), "latched cfg");
    an.removal_seen = 1'b1;
    wait_state(port_power_pkg::st_detect, 10);
    check({5'h00, sw.power, sw.bypass, att_on}, 8'h03, "attach rearmed");
    end_of_test();
  end
endmodule
